/* File: core/lcd_ps_pkg.sv */
// constants, instruction codes and carrier types of the power-save control block
//
// How it works
// - display off together with whole display on puts the block into power save.
// - power save halts the oscillator and disables the internal supply circuits.
// - power save stops panel drive; common and segment outputs sit at supply.
// - power save entry and exit leave memory and programmed modes untouched.
// - power save forces every panel bias voltage to the positive supply.
// - power save begins once display off and whole display on both hold, whichever of the two is taken second.
// - the normal-display instruction ends power save.
// - after release, outputs stay at supply until drive-voltage-set executes.
// - a 4-bit contrast level, written by instruction, picks one of 16 levels.
// - contrast level is zero after the reset pin or a zero write.
// - step-up runs only while the oscillator runs.
// - interface select high picks the parallel bus, low picks serial input.
// - serial mode allows no reads of status or display memory.
// - parallel mode moves instructions and data over an 8-bit two-way bus.
// - data/command select high marks display data, low marks an instruction.
// - drive-voltage-set enables bias and starts the drive waveform.
package lcd_ps_pkg;

	// ----------------------------------------------------------------
	// instruction codes; where a low bit carries a setting it is masked
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_DISPLAY_ONOFF = 8'hae;
	localparam logic [7:0] OP_WHOLE_ON      = 8'ha4;
	localparam logic [7:0] OP_SEG_REVERSE   = 8'ha0;
	localparam logic [7:0] OP_INVERSE       = 8'ha6;
	localparam logic [7:0] OP_ICON          = 8'haa;
	localparam logic [7:0] OP_SUPPLY_ON     = 8'h24;
	localparam logic [7:0] OP_DRIVE_SET     = 8'hed;
	localparam logic [7:0] OP_SOFT_RESET    = 8'he2;
	localparam logic [7:0] OP_SCAN_ORDER    = 8'hc0;
	localparam logic [7:0] OP_CONTRAST      = 8'h80;
	localparam logic [7:0] MASK_SETTING     = 8'hfe;
	localparam logic [7:0] MASK_SCAN        = 8'hf0;
	localparam logic [7:0] MASK_CONTRAST    = 8'hf0;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         BIT_SETTING      = 0;
	localparam int         BIT_SCAN         = 3;
	localparam int         CONTRAST_W       = 4;
	localparam logic [3:0] CONTRAST_RESET   = 4'h0;
	localparam logic [3:0] STATUS_LOW       = 4'h0;
	localparam logic [2:0] SERIAL_LAST      = 3'h7;

	// one accepted byte from the host
	typedef struct packed {
		logic       valid;
		logic       is_data;
		logic [7:0] value;
	} host_byte_t;

	// host pins after synchronisation
	typedef struct packed {
		logic       cs_n;
		logic       dc_sel;
		logic       rd_n;
		logic       wr_n;
		logic       parallel;
		logic       style68;
		logic       si;
		logic       scl;
		logic [7:0] d;
	} host_pins_t;

endpackage : lcd_ps_pkg

/* File: core/host_port.sv */
// host interface: pin synchronisers, parallel and serial byte capture, read window
module host_port (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire lcd_ps_pkg::host_pins_t pins_async,
	output lcd_ps_pkg::host_byte_t      byte_out,
	output logic                        read_on,
	output logic                        read_is_data
);
	import lcd_ps_pkg::*;

	// ----------------------------------------------------------------
	// two-stage synchronisers; stage two and its one-cycle-delayed copy are read by logic, stage one is not
	// ----------------------------------------------------------------
	host_pins_t meta_r;
	host_pins_t pin_r;
	host_pins_t prev_r;
	logic [7:0] shift_r;
	logic [2:0] count_r;
	host_byte_t byte_r;
	logic       read_r;
	logic       read_dc_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			pin_r  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			prev_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
		end else begin
			meta_r <= pins_async;
			pin_r  <= meta_r;
			prev_r <= pin_r;
		end
	end

	// ----------------------------------------------------------------
	// strobe decode
	// ----------------------------------------------------------------
	wire selected   = !pin_r.cs_n;
	wire wr_rise80  = pin_r.wr_n && !prev_r.wr_n;
	wire e_fall68   = !pin_r.rd_n && prev_r.rd_n && !pin_r.wr_n;
	wire par_write  = selected && pin_r.parallel && (pin_r.style68 ? e_fall68 : wr_rise80);
	wire scl_rise   = pin_r.scl && !prev_r.scl;
	wire ser_shift  = selected && !pin_r.parallel && scl_rise;
	wire ser_done   = ser_shift && (count_r == SERIAL_LAST);
	wire rd_80      = !pin_r.rd_n;
	wire rd_68      = pin_r.rd_n && pin_r.wr_n;
	wire read_nxt   = selected && pin_r.parallel && (pin_r.style68 ? rd_68 : rd_80);
	wire [7:0] ser_byte = {shift_r[6:0], pin_r.si};

	// serial shifter, msb first, cleared whenever the chip is deselected
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= 8'h00;
			count_r <= 3'h0;
		end else if (!selected || pin_r.parallel) begin
			shift_r <= 8'h00;
			count_r <= 3'h0;
		end else if (ser_shift) begin
			shift_r <= ser_byte;
			count_r <= count_r + 3'h1;
		end
	end

	// one-cycle byte pulse; select line sampled with the byte marks its kind
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_r    <= '0;
			read_r    <= 1'b0;
			read_dc_r <= 1'b0;
		end else begin
			byte_r.valid   <= par_write || ser_done;
			byte_r.is_data <= pin_r.dc_sel;
			byte_r.value   <= ser_done ? ser_byte : pin_r.d;
			read_r         <= read_nxt;
			read_dc_r      <= pin_r.dc_sel;
		end
	end

	assign byte_out     = byte_r;
	assign read_on      = read_r;
	assign read_is_data = read_dc_r;

endmodule : host_port

/* File: core/power_save_ctrl.sv */
// power-save, contrast level, supply enables and status of the panel controller
module power_save_ctrl (
	input  wire logic                   CLK,
	input  wire logic                   RST_N,
	input  wire logic                   EXTERNAL_RESET_PIN_N,
	input  wire logic                   CS_N,
	input  wire logic                   DATA_COMMAND_SELECT,
	input  wire logic                   RD_N,
	input  wire logic                   WR_N,
	input  wire logic                   PARALLEL_SELECT,
	input  wire logic                   BUS_STYLE_SELECT,
	input  wire logic                   SERIAL_IN,
	input  wire logic                   SERIAL_CLK,
	input  wire logic                   SUPPLY_MODE_PIN_FIRST,
	input  wire logic                   SUPPLY_MODE_PIN_SECOND,
	input  wire logic [7:0]             D_IN,
	input  wire logic [7:0]             RAM_RD_DATA,
	output logic      [7:0]             D_OUT,
	output logic                        D_OE,
	output lcd_ps_pkg::host_byte_t      RAM_WRITE,
	output logic                        POWER_SAVE,
	output logic                        OSC_RUN,
	output logic                        SUPPLY_EN,
	output logic                        STEPUP_EN,
	output logic                        BIAS_EN,
	output logic                        BIAS_AT_VDD,
	output logic                        DRIVE_WAVE_EN,
	output logic                        OUTPUTS_AT_VDD,
	output logic [3:0]                  CONTRAST_LEVEL,
	output logic                        CONTRAST_ACTIVE,
	output logic                        SEG_REVERSE,
	output logic                        INVERSE_DISPLAY,
	output logic                        WHOLE_ON,
	output logic                        ICON_DUTY,
	output logic                        SCAN_ORDER
);
	import lcd_ps_pkg::*;

	// ----------------------------------------------------------------
	// host port and pin synchronisers
	// ----------------------------------------------------------------
	host_byte_t hb;
	logic       read_on;
	logic       read_is_data;
	logic [3:0] sync_r;
	logic [3:0] pin_r;

	host_port u_port (
		.clk          (CLK),
		.rst_n        (RST_N),
		.pins_async   ({CS_N, DATA_COMMAND_SELECT, RD_N, WR_N, PARALLEL_SELECT,
		                BUS_STYLE_SELECT, SERIAL_IN, SERIAL_CLK, D_IN}),
		.byte_out     (hb),
		.read_on      (read_on),
		.read_is_data (read_is_data)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_r <= 4'h0;
			pin_r  <= 4'h0;
		end else begin
			sync_r <= {EXTERNAL_RESET_PIN_N, SUPPLY_MODE_PIN_FIRST,
			           SUPPLY_MODE_PIN_SECOND, PARALLEL_SELECT};
			pin_r  <= sync_r;
		end
	end

	wire pin_reset = !pin_r[3];
	wire both_high = pin_r[2] && pin_r[1];
	wire par_mode  = pin_r[0];

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	wire       cmd        = hb.valid && !hb.is_data;
	wire [7:0] op         = hb.value;
	wire       set_bit    = op[BIT_SETTING];
	wire       is_disp    = cmd && ((op & MASK_SETTING) == OP_DISPLAY_ONOFF);
	wire       is_whole   = cmd && ((op & MASK_SETTING) == OP_WHOLE_ON);
	wire       is_segrev  = cmd && ((op & MASK_SETTING) == OP_SEG_REVERSE);
	wire       is_inv     = cmd && ((op & MASK_SETTING) == OP_INVERSE);
	wire       is_icon    = cmd && ((op & MASK_SETTING) == OP_ICON);
	wire       is_supply  = cmd && ((op & MASK_SETTING) == OP_SUPPLY_ON);
	wire       is_drive   = cmd && (op == OP_DRIVE_SET);
	wire       is_sreset  = cmd && (op == OP_SOFT_RESET);
	wire       is_scan    = cmd && ((op & MASK_SCAN) == OP_SCAN_ORDER);
	wire       is_contr   = cmd && ((op & MASK_CONTRAST) == OP_CONTRAST);

	// ----------------------------------------------------------------
	// stored settings
	// ----------------------------------------------------------------
	logic       disp_on_r, whole_r, segrev_r, inv_r, icon_r, supply_r, scan_r, drive_r;
	logic [3:0] contrast_r;

	wire disp_on_nxt = is_disp ? set_bit : disp_on_r;
	wire whole_nxt   = is_whole ? set_bit : whole_r;
	wire ps_nxt      = !disp_on_nxt && whole_nxt;
	wire ps_enter    = ps_nxt && !(!disp_on_r && whole_r);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			disp_on_r  <= 1'b0;
			whole_r    <= 1'b0;
			segrev_r   <= 1'b0;
			inv_r      <= 1'b0;
			icon_r     <= 1'b0;
			supply_r   <= 1'b0;
			scan_r     <= 1'b0;
			drive_r    <= 1'b0;
			contrast_r <= CONTRAST_RESET;
		end else if (pin_reset) begin
			disp_on_r  <= 1'b0;
			whole_r    <= 1'b0;
			segrev_r   <= 1'b0;
			inv_r      <= 1'b0;
			icon_r     <= 1'b0;
			supply_r   <= 1'b0;
			scan_r     <= 1'b0;
			drive_r    <= 1'b0;
			contrast_r <= CONTRAST_RESET;
		end else begin
			// other settings change by their own instruction; soft reset also clears scan order and contrast, power save entry clears drive
			disp_on_r <= disp_on_nxt;
			whole_r   <= whole_nxt;
			if (is_segrev) segrev_r <= set_bit;
			if (is_inv) inv_r <= set_bit;
			if (is_icon) icon_r <= set_bit;
			if (is_supply) supply_r <= set_bit;
			if (is_scan || is_sreset) scan_r <= is_scan ? op[BIT_SCAN] : 1'b0;
			if (is_contr) contrast_r <= op[CONTRAST_W-1:0];
			else if (is_sreset) contrast_r <= CONTRAST_RESET;
			if (ps_enter) drive_r <= 1'b0;
			else if (is_drive) drive_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// power and drive outputs, all registered
	// ----------------------------------------------------------------
	logic ps_r;
	wire  osc_nxt   = !ps_r;
	wire  sup_nxt   = supply_r && !ps_r;
	wire  wave_nxt  = drive_r && !ps_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ps_r            <= 1'b0;
			POWER_SAVE      <= 1'b0;
			OSC_RUN         <= 1'b1;
			SUPPLY_EN       <= 1'b0;
			STEPUP_EN       <= 1'b0;
			BIAS_EN         <= 1'b0;
			BIAS_AT_VDD     <= 1'b1;
			DRIVE_WAVE_EN   <= 1'b0;
			OUTPUTS_AT_VDD  <= 1'b1;
			CONTRAST_LEVEL  <= CONTRAST_RESET;
			CONTRAST_ACTIVE <= 1'b0;
		end else begin
			ps_r            <= pin_reset ? 1'b0 : ps_nxt;
			POWER_SAVE      <= ps_r;
			OSC_RUN         <= osc_nxt;
			SUPPLY_EN       <= sup_nxt;
			STEPUP_EN       <= sup_nxt && osc_nxt;
			BIAS_EN         <= wave_nxt;
			BIAS_AT_VDD     <= !wave_nxt;
			DRIVE_WAVE_EN   <= wave_nxt;
			OUTPUTS_AT_VDD  <= !wave_nxt;
			CONTRAST_LEVEL  <= contrast_r;
			CONTRAST_ACTIVE <= sup_nxt && !both_high;
		end
	end

	// ----------------------------------------------------------------
	// mode outputs, data forwarding and reads
	// ----------------------------------------------------------------
	wire [7:0] status = {pin_reset, !segrev_r, !disp_on_r, pin_reset, STATUS_LOW};
	wire       oe_nxt = read_on && par_mode;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SEG_REVERSE     <= 1'b0;
			INVERSE_DISPLAY <= 1'b0;
			WHOLE_ON        <= 1'b0;
			ICON_DUTY       <= 1'b0;
			SCAN_ORDER      <= 1'b0;
			RAM_WRITE       <= '0;
			D_OUT           <= 8'h00;
			D_OE            <= 1'b0;
		end else begin
			SEG_REVERSE     <= segrev_r;
			INVERSE_DISPLAY <= inv_r;
			WHOLE_ON        <= whole_r;
			ICON_DUTY       <= icon_r;
			SCAN_ORDER      <= scan_r;
			RAM_WRITE       <= (hb.valid && hb.is_data) ? hb : '0;
			D_OUT           <= read_is_data ? RAM_RD_DATA : status;
			D_OE            <= oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N || pin_reset);

	sequence s_off_then_whole;
		(!disp_on_r && is_whole && set_bit) ##1 1'b1;
	endsequence

	chk_save_entry: assert property (s_off_then_whole |-> ps_r)
		else $error("power save not entered after whole display on");
	chk_save_follows: assert property (ps_r == (!disp_on_r && whole_r))
		else $error("power save does not follow the display flags");
	chk_osc_halt: assert property (ps_r |=> (!OSC_RUN && !SUPPLY_EN))
		else $error("oscillator or supply running in power save");
	chk_drive_stop: assert property (ps_r |=> (OUTPUTS_AT_VDD && !DRIVE_WAVE_EN))
		else $error("panel drive active in power save");
	chk_bias_vdd: assert property (ps_r |=> (BIAS_AT_VDD && !BIAS_EN))
		else $error("bias not at supply in power save");
	chk_modes_kept: assert property (!(is_segrev || is_inv) |=> $stable(segrev_r) && $stable(inv_r))
		else $error("mode changed without its instruction");
	chk_release: assert property ((is_whole && !set_bit) |=> !ps_r ##1 !POWER_SAVE)
		else $error("normal display did not end power save");
	chk_wait_drive: assert property ((ps_r && !is_drive) |=> !drive_r)
		else $error("drive waveform armed before drive-voltage-set");
	chk_drive_start: assert property ((is_drive && !ps_nxt) |=> ##1 (DRIVE_WAVE_EN && BIAS_EN))
		else $error("drive-voltage-set did not start drive");
	chk_contrast_write: assert property (is_contr |=> ##1 (CONTRAST_LEVEL == $past(op[3:0], 2)))
		else $error("contrast level not taken");
	chk_stepup_osc: assert property (STEPUP_EN |-> OSC_RUN)
		else $error("step-up running without oscillator");
	chk_serial_noread: assert property (!par_mode |=> !D_OE)
		else $error("read driven in serial mode");

endmodule : power_save_ctrl

/* File: test/host_model.sv */
// host processor model driving the parallel and serial instruction bus
module host_model (
	input  wire logic       clk,
	input  wire logic       par,
	input  wire logic       m68,
	input  wire logic [7:0] bus,
	input  wire logic       oe,
	output logic            cs_n,
	output logic            dc,
	output logic            rd_n,
	output logic            wr_n,
	output logic [7:0]      d,
	output logic            si,
	output logic            scl
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{cs_n, dc, rd_n, wr_n, si, scl} = 6'b101100;
		d = 8'h00;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold

	// one whole byte per frame or strobe; released lines show the inverse
	task automatic put(input logic is_data, input logic [7:0] v);
		// strobe idle level settles a cycle ahead, so a style change gives no false edge
		rd_n = ~m68;
		@(negedge clk);
		cs_n = 1'b0;
		dc   = is_data;
		if (!par) begin
			for (int i = 7; i >= 0; i--) begin
				si = v[i];
				hold(4);
				scl = 1'b1;
				hold(4);
				scl = 1'b0;
			end
			si = ~v[0];
		end else begin
			d = v;
			wr_n = 1'b0;
			hold(1);
			if (m68) rd_n = 1'b1;
			hold(4);
			if (m68) rd_n = 1'b0;
			else wr_n = 1'b1;
			hold(4);
			wr_n = 1'b1;
			d = ~v;
		end
		cs_n = 1'b1;
		dc   = ~is_data;
	endtask : put

	// read strobe held until the answer has settled, then released
	task automatic get(input logic is_data, output logic [7:0] v, output logic en);
		@(negedge clk);
		cs_n = 1'b0;
		dc   = is_data;
		wr_n = 1'b1;
		rd_n = m68;
		hold(8);
		v    = bus;
		en   = oe;
		rd_n = ~m68;
		hold(6);
		cs_n = 1'b1;
	endtask : get
endmodule : host_model

/* File: test/tb.sv */
// self-checking bench of the power-save control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lcd_ps_pkg::*;

	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic       clk = 1'b0, rst_n = 1'b0, ext_n = 1'b0, par = 1'b1, par_h = 1'b1;
	logic       m68 = 1'b0, t1 = 1'b0, t2 = 1'b0, oe_seen;
	logic [7:0] ram_rd = 8'h3c, rd_v;
	logic       cs_n, dc, rd_n, wr_n, si, scl, d_oe, ps, osc, sup, stu, bias, bvdd, wave, ovdd;
	logic       act, segr, whole, inv, icon, scan;
	logic [7:0] host_d, d_out, bus;
	logic [3:0] lvl;
	host_byte_t ramw, ram_last;
	int         ram_cnt = 0, miscompares = 0, checks = 0;

	assign bus = d_oe ? d_out : host_d;
	always #2 clk = ~clk;
	always @(posedge clk) if (ramw.valid === 1'b1) begin
		ram_cnt++;
		ram_last <= ramw;
	end

	host_model host_model_inst (.clk(clk), .par(par_h), .m68(m68), .bus(bus), .oe(d_oe),
		.cs_n(cs_n), .dc(dc), .rd_n(rd_n), .wr_n(wr_n), .d(host_d), .si(si), .scl(scl));

	power_save_ctrl power_save_ctrl_inst (.CLK(clk), .RST_N(rst_n),
		.EXTERNAL_RESET_PIN_N(ext_n), .CS_N(cs_n), .DATA_COMMAND_SELECT(dc), .RD_N(rd_n),
		.WR_N(wr_n), .PARALLEL_SELECT(par), .BUS_STYLE_SELECT(m68), .SERIAL_IN(si),
		.SERIAL_CLK(scl), .SUPPLY_MODE_PIN_FIRST(t1), .SUPPLY_MODE_PIN_SECOND(t2),
		.D_IN(bus), .RAM_RD_DATA(ram_rd), .D_OUT(d_out), .D_OE(d_oe), .RAM_WRITE(ramw),
		.POWER_SAVE(ps), .OSC_RUN(osc), .SUPPLY_EN(sup), .STEPUP_EN(stu), .BIAS_EN(bias),
		.BIAS_AT_VDD(bvdd), .DRIVE_WAVE_EN(wave), .OUTPUTS_AT_VDD(ovdd),
		.CONTRAST_LEVEL(lvl), .CONTRAST_ACTIVE(act), .SEG_REVERSE(segr),
		.INVERSE_DISPLAY(inv), .WHOLE_ON(whole), .ICON_DUTY(icon), .SCAN_ORDER(scan));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cmd(input logic is_data, input logic [7:0] v);
		host_model_inst.put(is_data, v);
		repeat (12) @(negedge clk);
	endtask : cmd

	// flags packed as power save, osc, supply, step-up, bias, bias at vdd, wave, outputs at vdd
	task automatic flags(input logic [7:0] exp);
		chk("power flags", exp, {ps, osc, sup, stu, bias, bvdd, wave, ovdd});
	endtask : flags

	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_reset;
		flags(8'h45);
		chk("contrast", 8'h0, {4'h0, lvl});
		host_model_inst.get(1'b0, rd_v, oe_seen);
		chk("status", 8'h60, rd_v);
		chk("drive enable", 8'h1, {7'h0, oe_seen});
	endtask : sc_reset

	task automatic sc_contrast;
		for (int i = 0; i < 16; i++) begin
			cmd(1'b0, OP_CONTRAST | 8'(i));
			chk("contrast", 8'(i), {4'h0, lvl});
		end
		cmd(1'b0, OP_CONTRAST);
		chk("contrast zero", 8'h0, {4'h0, lvl});
		t2 = 1'b1;
		cmd(1'b0, OP_SUPPLY_ON | 8'h01);
		chk("contrast active", 8'h1, {7'h0, act});
		flags(8'h75);
		t1 = 1'b1;
		repeat (10) @(negedge clk);
		chk("contrast both high", 8'h0, {7'h0, act});
		t1 = 1'b0;
		cmd(1'b0, OP_CONTRAST | 8'h09);
	endtask : sc_contrast

	task automatic sc_power;
		cmd(1'b0, OP_SEG_REVERSE | 8'h01);
		cmd(1'b0, OP_DRIVE_SET);
		flags(8'h7a);
		cmd(1'b0, OP_DISPLAY_ONOFF | 8'h01);
		cmd(1'b0, OP_DISPLAY_ONOFF);
		flags(8'h7a);
		cmd(1'b0, OP_WHOLE_ON | 8'h01);
		flags(8'h85);
		chk("kept modes", 8'h9f, {lvl, segr, whole, 2'h3});
		cmd(1'b0, OP_WHOLE_ON);
		flags(8'h75);
		cmd(1'b0, OP_DISPLAY_ONOFF | 8'h01);
		flags(8'h75);
		cmd(1'b0, OP_DRIVE_SET);
		flags(8'h7a);
		chk("kept after", 8'h9a, {lvl, segr, whole, 2'h2});
	endtask : sc_power

	task automatic sc_modes;
		cmd(1'b0, OP_INVERSE | 8'h01);
		cmd(1'b0, OP_ICON | 8'h01);
		cmd(1'b0, OP_SCAN_ORDER | 8'h08);
		chk("mode set", 8'h07, {5'h0, inv, icon, scan});
		cmd(1'b0, OP_SOFT_RESET);
		chk("reset instruction", 8'h06, {5'h0, inv, icon, scan});
		chk("contrast cleared", 8'h0, {4'h0, lvl});
	endtask : sc_modes

	task automatic sc_data(input logic [7:0] v);
		int n0;
		n0 = ram_cnt;
		cmd(1'b1, v);
		cmd(1'b0, OP_INVERSE);
		chk("ram writes", 8'h1, 8'(ram_cnt - n0));
		chk("ram byte", v, ram_last.value);
		chk("ram kind", 8'h1, {7'h0, ram_last.is_data});
	endtask : sc_data

	task automatic sc_bus_modes;
		host_model_inst.get(1'b1, rd_v, oe_seen);
		chk("data read", ram_rd, rd_v);
		m68 = 1'b1;
		cmd(1'b0, OP_CONTRAST | 8'h03);
		chk("contrast 68", 8'h3, {4'h0, lvl});
		host_model_inst.get(1'b0, rd_v, oe_seen);
		chk("status 68", 8'h00, rd_v);
		m68 = 1'b0;
		par = 1'b0;
		par_h = 1'b0;
		cmd(1'b0, OP_CONTRAST | 8'h0a);
		chk("contrast serial", 8'ha, {4'h0, lvl});
		sc_data(8'h96);
		par_h = 1'b1;
		cmd(1'b0, OP_CONTRAST | 8'h01);
		chk("parallel refused", 8'ha, {4'h0, lvl});
		host_model_inst.get(1'b0, rd_v, oe_seen);
		chk("serial read", 8'h0, {7'h0, oe_seen});
		par = 1'b1;
	endtask : sc_bus_modes

	task automatic sc_pin_reset;
		ext_n = 1'b0;
		host_model_inst.get(1'b0, rd_v, oe_seen);
		chk("status in reset", 8'hf0, rd_v);
		ext_n = 1'b1;
		repeat (10) @(negedge clk);
		chk("pin reset", 8'h0, {inv, icon, scan, segr, lvl});
	endtask : sc_pin_reset

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		ext_n = 1'b1;
		repeat (8) @(negedge clk);
		sc_reset();
		sc_contrast();
		sc_power();
		sc_data(8'hc3);
		sc_modes();
		sc_bus_modes();
		sc_pin_reset();
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		$display("ERROR watchdog expected end seen hang");
		wrap_up();
	end
endmodule : tb
